// ===== rtl/rhsp_map.svh
`ifndef RHSP_MAP_SVH
`define RHSP_MAP_SVH
// How it works
// - The host resets by writing mode 07H, 06H, 07H with both selects high.
// - Reset bit one, zero, one returns the colour pipes to mux input A.
// - Mode value 07H selects a ten-bit host bus and ten-bit converters.
// - Both selects low load the address, low byte and upper bits apart.
// - At address 006H a write with select 1 high loads command two.
// - After low byte 05H the next select-low write loads command one.
// - Command three sits at 07H, and 40H gives 2:1 mux and clock / 4.
// - Command four sits at 08H, and 00H picks the default converter gain.
// - Command five sits at 0DH, and 40H picks the synthesizer clock.
// - The pixel mask sits at 04H with the upper address bits zero.
// - Synth V at 0FH, R at 0CH and command at 09H take select 1 writes.
// - Palette access starts at address 00H with select 0 high only.
// - Each palette entry takes three writes: red, green, then blue.
// - After the blue write the palette address advances by one.
// - The palette holds 00H to FFH and setup ends on the last blue write.
// - Mode bit zero written high, low, high gives one pulse on pipe_reset_out.
`define RHSP_ADR_PIXEL_MASK 11'h004
`define RHSP_ADR_CMD_ONE 11'h005
`define RHSP_ADR_CMD_TWO 11'h006
`define RHSP_ADR_CMD_THREE 11'h007
`define RHSP_ADR_CMD_FOUR 11'h008
`define RHSP_ADR_SYNTH_CMD 11'h009
`define RHSP_ADR_SYNTH_R 11'h00C
`define RHSP_ADR_CMD_FIVE 11'h00D
`define RHSP_ADR_SYNTH_V 11'h00F
`define RHSP_MODE_RESET_BIT 0
`define RHSP_MODE_BUS10_BIT 1
`define RHSP_MODE_DAC10_BIT 2
`define RHSP_CMD3_MUX_BIT 6
`define RHSP_CMD5_PLL_BIT 6
`define RHSP_CMD_ONE_LOW 8'h05
`define RHSP_MODE_FULL 8'h07
`define RHSP_REG_RESET 8'h00
`define RHSP_PAL_LAST 8'hFF
`endif

// ===== rtl/rhsp_pkg.sv
package rhsp_pkg;
  typedef enum logic [1:0] {
    RHSP_TGT_ADDR, RHSP_TGT_PAL, RHSP_TGT_CTRL, RHSP_TGT_MODE
  } rhsp_tgt_t;
  typedef enum {RHSP_RS_ONE_A, RHSP_RS_ZERO, RHSP_RS_ONE_B} rhsp_rst_t;
  typedef struct packed {
    logic [9:0] red;
    logic [9:0] green;
    logic [9:0] blue;
  } rhsp_rgb_t;
  typedef struct packed {
    logic [7:0] pixel_mask;
    logic [7:0] command_one;
    logic [7:0] command_two;
    logic [7:0] command_three;
    logic [7:0] command_four;
    logic [7:0] command_five;
    logic [7:0] synth_command;
    logic [7:0] synth_ref_divider;
    logic [7:0] synth_fb_divider;
  } rhsp_cfg_t;
endpackage : rhsp_pkg

// ===== rtl/rhsp_host_port.sv
`timescale 1ns/1ps
`include "rhsp_map.svh"
module rhsp_host_port (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic chip_en_n_in,
  input wire logic read_nwrite_in,
  input wire logic ctrl_select_1_in,
  input wire logic ctrl_select_0_in,
  input wire logic [9:0] data_in,
  input wire logic [7:0] pal_rd_addr_in,
  output logic [7:0] mode_reg_out,
  output rhsp_pkg::rhsp_cfg_t cfg_out,
  output logic [10:0] addr_out,
  output logic [1:0] pal_phase_out,
  output logic pipe_reset_out,
  output logic bus_10bit_out,
  output logic dac_10bit_out,
  output logic mux_2to1_out,
  output logic synth_clk_sel_out,
  output logic pal_init_done_out,
  output rhsp_pkg::rhsp_rgb_t pal_rd_data_out
);
  // ****************************************
  // Write decode
  // ****************************************
  logic wr_en;
  rhsp_pkg::rhsp_tgt_t tgt;
  logic [7:0] mode_q;
  rhsp_pkg::rhsp_cfg_t cfg_q;
  logic [10:0] addr_q;
  logic [1:0] phase_q;
  logic [9:0] red_q;
  logic [9:0] green_q;
  logic pipe_rst_q;
  logic done_q;
  rhsp_pkg::rhsp_rst_t rs_q;
  rhsp_pkg::rhsp_rgb_t pal_mem [256];
  rhsp_pkg::rhsp_rgb_t rd_q;
  logic addr_hi_next_q;
  logic cmd_one_sel;
  logic blue_wr;

  assign wr_en = !chip_en_n_in && !read_nwrite_in;
  assign tgt = rhsp_pkg::rhsp_tgt_t'({ctrl_select_1_in, ctrl_select_0_in});

  function automatic logic hit(input logic [10:0] a, input logic [10:0] r);
    hit = (a == r);
  endfunction : hit

  function automatic logic is_wr(input logic en, input rhsp_pkg::rhsp_tgt_t t,
    input rhsp_pkg::rhsp_tgt_t want);
    is_wr = en && (t == want);
  endfunction : is_wr

  // Low byte 05H turns the pending upper-bits write into a command one
  // write, so after low byte 05H the upper address bits keep their earlier value
  assign cmd_one_sel = addr_hi_next_q && addr_q[7:0] == `RHSP_CMD_ONE_LOW;
  assign blue_wr = is_wr(wr_en, tgt, rhsp_pkg::RHSP_TGT_PAL)
    && phase_q == 2'h2;

  // ****************************************
  // Mode register and pipeline reset
  // ****************************************
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      mode_q <= `RHSP_REG_RESET;
    end else if (wr_en && tgt == rhsp_pkg::RHSP_TGT_MODE) begin
      mode_q <= data_in[7:0];
    end
  end

  // Track one, zero, one on the reset bit; last one fires a single pulse
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rs_q <= rhsp_pkg::RHSP_RS_ONE_A;
      pipe_rst_q <= 1'b0;
    end else begin
      pipe_rst_q <= 1'b0;
      if (wr_en && tgt == rhsp_pkg::RHSP_TGT_MODE) begin
        unique case (rs_q)
          rhsp_pkg::RHSP_RS_ONE_A: begin
            if (data_in[`RHSP_MODE_RESET_BIT]) begin
              rs_q <= rhsp_pkg::RHSP_RS_ZERO;
            end
          end
          rhsp_pkg::RHSP_RS_ZERO: begin
            if (!data_in[`RHSP_MODE_RESET_BIT]) begin
              rs_q <= rhsp_pkg::RHSP_RS_ONE_B;
            end
          end
          rhsp_pkg::RHSP_RS_ONE_B: begin
            if (data_in[`RHSP_MODE_RESET_BIT]) begin
              pipe_rst_q <= 1'b1;
              rs_q <= rhsp_pkg::RHSP_RS_ZERO;
            end else begin
              rs_q <= rhsp_pkg::RHSP_RS_ONE_B;
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // Address register
  // ****************************************
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      addr_q <= 11'h000;
      phase_q <= 2'h0;
    end else if (wr_en && tgt == rhsp_pkg::RHSP_TGT_ADDR) begin
      // Upper bits follow the low byte; any other write restarts at the
      // low byte, and low byte 05H hands the second write to command one
      phase_q <= 2'h0;
      if (!addr_hi_next_q) begin
        addr_q[7:0] <= data_in[7:0];
      end else if (!cmd_one_sel) begin
        addr_q[10:8] <= data_in[2:0];
      end
    end else if (wr_en && tgt == rhsp_pkg::RHSP_TGT_PAL) begin
      if (phase_q == 2'h2) begin
        phase_q <= 2'h0;
        addr_q <= {3'h0, addr_q[7:0] + 8'h01};
      end else begin
        phase_q <= phase_q + 2'h1;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      addr_hi_next_q <= 1'b0;
    end else if (wr_en) begin
      addr_hi_next_q <= (tgt == rhsp_pkg::RHSP_TGT_ADDR) && !addr_hi_next_q;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cfg_q <= '0;
    end else if (cmd_one_sel
                 && is_wr(wr_en, tgt, rhsp_pkg::RHSP_TGT_ADDR)) begin
      cfg_q.command_one <= data_in[7:0];
    end else if (wr_en && tgt == rhsp_pkg::RHSP_TGT_CTRL) begin
      unique case (addr_q)
        `RHSP_ADR_CMD_ONE: cfg_q.command_one <= data_in[7:0];
        `RHSP_ADR_PIXEL_MASK: cfg_q.pixel_mask <= data_in[7:0];
        `RHSP_ADR_CMD_TWO: cfg_q.command_two <= data_in[7:0];
        `RHSP_ADR_CMD_THREE: cfg_q.command_three <= data_in[7:0];
        `RHSP_ADR_CMD_FOUR: cfg_q.command_four <= data_in[7:0];
        `RHSP_ADR_CMD_FIVE: cfg_q.command_five <= data_in[7:0];
        `RHSP_ADR_SYNTH_CMD: cfg_q.synth_command <= data_in[7:0];
        `RHSP_ADR_SYNTH_R: cfg_q.synth_ref_divider <= data_in[7:0];
        `RHSP_ADR_SYNTH_V: cfg_q.synth_fb_divider <= data_in[7:0];
        default: cfg_q <= cfg_q;
      endcase
    end
  end

  // ****************************************
  // Colour palette
  // ****************************************
  // Red and green wait here so that an entry changes in one step, on blue
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      red_q <= 10'h000;
    end else if (is_wr(wr_en, tgt, rhsp_pkg::RHSP_TGT_PAL)
                 && phase_q == 2'h0) begin
      red_q <= data_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      green_q <= 10'h000;
    end else if (is_wr(wr_en, tgt, rhsp_pkg::RHSP_TGT_PAL)
                 && phase_q == 2'h1) begin
      green_q <= data_in;
    end
  end

  // No reset on the array: the contents mean nothing until the host has
  // loaded them, and a reset would keep the array out of block memory
  always_ff @(posedge core_clk_in) begin
    if (blue_wr) begin
      pal_mem[addr_q[7:0]] <= {red_q, green_q, data_in};
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rd_q <= '0;
    end else begin
      rd_q <= pal_mem[pal_rd_addr_in];
    end
  end

  // Sticky until reset, so a slow host can still see it after wrapping
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      done_q <= 1'b0;
    end else if (blue_wr && addr_q[7:0] == `RHSP_PAL_LAST) begin
      done_q <= 1'b1;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign mode_reg_out = mode_q;
  assign cfg_out = cfg_q;
  assign addr_out = addr_q;
  assign pal_phase_out = phase_q;
  assign pipe_reset_out = pipe_rst_q;
  assign bus_10bit_out = mode_q[`RHSP_MODE_BUS10_BIT];
  assign dac_10bit_out = mode_q[`RHSP_MODE_DAC10_BIT];
  assign mux_2to1_out = cfg_q.command_three[`RHSP_CMD3_MUX_BIT];
  assign synth_clk_sel_out = cfg_q.command_five[`RHSP_CMD5_PLL_BIT];
  assign pal_init_done_out = done_q;
  assign pal_rd_data_out = rd_q;

  // ****************************************
  // Checks
  // ****************************************
  property p_mode_load;
    @(posedge core_clk_in) disable iff (rst_in)
    is_wr(wr_en, tgt, rhsp_pkg::RHSP_TGT_MODE)
      |=> mode_reg_out == $past(data_in[7:0]);
  endproperty
  a_mode_load: assert property (p_mode_load)
    else $error("mode register did not take the written value");

  property p_pipe_pulse;
    @(posedge core_clk_in) disable iff (rst_in)
    pipe_reset_out
      |=> !pipe_reset_out;
  endproperty
  a_pipe_pulse: assert property (p_pipe_pulse)
    else $error("pipeline reset lasted more than one cycle");

  property p_pipe_cause;
    @(posedge core_clk_in) disable iff (rst_in)
    pipe_reset_out |-> $past(tgt) == rhsp_pkg::RHSP_TGT_MODE
      && $past(wr_en && data_in[`RHSP_MODE_RESET_BIT]);
  endproperty
  a_pipe_cause: assert property (p_pipe_cause)
    else $error("pipeline reset without a mode write of one");

  property p_bus_mode;
    @(posedge core_clk_in) disable iff (rst_in)
    mode_reg_out == `RHSP_MODE_FULL
      |-> bus_10bit_out && dac_10bit_out;
  endproperty
  a_bus_mode: assert property (p_bus_mode)
    else $error("full mode value did not select ten-bit operation");

  property p_addr_low;
    @(posedge core_clk_in) disable iff (rst_in)
    is_wr(wr_en, tgt, rhsp_pkg::RHSP_TGT_ADDR) && !addr_hi_next_q
      |=> addr_out[7:0] == $past(data_in[7:0]);
  endproperty
  a_addr_low: assert property (p_addr_low)
    else $error("address low byte not loaded");

  property p_addr_high;
    @(posedge core_clk_in) disable iff (rst_in)
    addr_hi_next_q && !cmd_one_sel && wr_en && tgt == rhsp_pkg::RHSP_TGT_ADDR
      |=> addr_out[10:8] == $past(data_in[2:0]);
  endproperty
  a_addr_high: assert property (p_addr_high)
    else $error("address upper bits not loaded");

  property p_cmd_one;
    @(posedge core_clk_in) disable iff (rst_in)
    cmd_one_sel && is_wr(wr_en, tgt, rhsp_pkg::RHSP_TGT_ADDR)
      |=> cfg_out.command_one == $past(data_in[7:0]);
  endproperty
  a_cmd_one: assert property (p_cmd_one)
    else $error("command one not loaded after low byte 05");

  property p_cmd_two;
    @(posedge core_clk_in) disable iff (rst_in)
    hit(addr_out, `RHSP_ADR_CMD_TWO)
      && is_wr(wr_en, tgt, rhsp_pkg::RHSP_TGT_CTRL)
      |=> cfg_out.command_two == $past(data_in[7:0]);
  endproperty
  a_cmd_two: assert property (p_cmd_two)
    else $error("command two not loaded");

  property p_cmd_three;
    @(posedge core_clk_in) disable iff (rst_in)
    hit(addr_out, `RHSP_ADR_CMD_THREE)
      && is_wr(wr_en, tgt, rhsp_pkg::RHSP_TGT_CTRL)
      |=> cfg_out.command_three == $past(data_in[7:0]);
  endproperty
  a_cmd_three: assert property (p_cmd_three)
    else $error("command three not loaded");

  property p_mask;
    @(posedge core_clk_in) disable iff (rst_in)
    hit(addr_out, `RHSP_ADR_PIXEL_MASK)
      && is_wr(wr_en, tgt, rhsp_pkg::RHSP_TGT_CTRL)
      |=> cfg_out.pixel_mask == $past(data_in[7:0]);
  endproperty
  a_mask: assert property (p_mask)
    else $error("pixel mask not loaded");

  property p_synth_v;
    @(posedge core_clk_in) disable iff (rst_in)
    hit(addr_out, `RHSP_ADR_SYNTH_V)
      && is_wr(wr_en, tgt, rhsp_pkg::RHSP_TGT_CTRL)
      |=> cfg_out.synth_fb_divider == $past(data_in[7:0]);
  endproperty
  a_synth_v: assert property (p_synth_v)
    else $error("synthesizer feedback divider not loaded");

  property p_pal_order;
    @(posedge core_clk_in) disable iff (rst_in)
    is_wr(wr_en, tgt, rhsp_pkg::RHSP_TGT_PAL) && pal_phase_out != 2'h2
      |=> pal_phase_out == 2'($past(pal_phase_out) + 2'h1);
  endproperty
  a_pal_order: assert property (p_pal_order)
    else $error("palette colour phase did not step");

  property p_pal_advance;
    @(posedge core_clk_in) disable iff (rst_in)
    blue_wr
      |=> addr_out[7:0] == 8'($past(addr_out[7:0]) + 8'h01);
  endproperty
  a_pal_advance: assert property (p_pal_advance)
    else $error("palette address did not advance after blue");

  property p_pal_done;
    @(posedge core_clk_in) disable iff (rst_in)
    blue_wr && addr_out[7:0] == `RHSP_PAL_LAST
      |=> pal_init_done_out;
  endproperty
  a_pal_done: assert property (p_pal_done)
    else $error("palette setup not flagged after last entry");

  property p_addr_restart;
    @(posedge core_clk_in) disable iff (rst_in)
    is_wr(wr_en, tgt, rhsp_pkg::RHSP_TGT_ADDR)
      |=> pal_phase_out == 2'h0;
  endproperty
  a_addr_restart: assert property (p_addr_restart)
    else $error("address write did not restart the colour phase");

  property p_read_ignored;
    @(posedge core_clk_in) disable iff (rst_in)
    !wr_en
      |=> $stable(cfg_out) && $stable(mode_reg_out) && $stable(addr_out);
  endproperty
  a_read_ignored: assert property (p_read_ignored)
    else $error("registers changed without a write");
endmodule : rhsp_host_port

// ===== dv/rhsp_host_model.sv
`timescale 1ns/1ps
// ****************
// Host bus driver
// ****************
module rhsp_host_model (
  input wire logic clk_in,
  output logic chip_en_n_out,
  output logic read_nwrite_out,
  output logic ctrl_select_1_out,
  output logic ctrl_select_0_out,
  output logic [9:0] data_out
);
  initial begin
    chip_en_n_out = 1'h1;
    read_nwrite_out = 1'h1;
    ctrl_select_1_out = 1'h0;
    ctrl_select_0_out = 1'h0;
    data_out = 10'h3FF;
  end
  // Held from one edge to the next, so the sampling edge sees it steady
  task automatic wr(input logic rnw, s1, s0, input logic [9:0] d);
    @(posedge clk_in);
    chip_en_n_out <= 1'h0;
    read_nwrite_out <= rnw;
    ctrl_select_1_out <= s1;
    ctrl_select_0_out <= s0;
    data_out <= d;
    @(posedge clk_in);
    chip_en_n_out <= 1'h1;
    read_nwrite_out <= 1'h1;
    data_out <= ~d; // Released bus must not keep the last value
  endtask : wr
  task automatic adr(input logic [10:0] a);
    wr(1'h0, 1'h0, 1'h0, {2'h0, a[7:0]});
    wr(1'h0, 1'h0, 1'h0, {7'h00, a[10:8]});
  endtask : adr
endmodule : rhsp_host_model

// ===== dv/test_rhsp_host_port.sv
`timescale 1ns/1ps
// ****************
// Host port bench
// ****************
module test_rhsp_host_port;
  logic core_clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic ce_n, rnw, s1, s0, pipe_rst, done, b10, d10, mux, syn;
  logic [9:0] data;
  logic [7:0] rd_adr = 8'h00;
  logic [7:0] mode;
  logic [10:0] adr_seen;
  logic [1:0] ph;
  logic seen = 1'h0;
  rhsp_pkg::rhsp_cfg_t cfg;
  rhsp_pkg::rhsp_rgb_t rd;
  int bad_count = 0;
  int n_tests = 0;
  always #10 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) if (pipe_rst === 1'h1) seen <= 1'h1;
  rhsp_host_model u_rhsp_host_model (.clk_in(core_clk_in),
    .chip_en_n_out(ce_n), .read_nwrite_out(rnw), .ctrl_select_1_out(s1),
    .ctrl_select_0_out(s0), .data_out(data));
  rhsp_host_port u_rhsp_host_port (.core_clk_in(core_clk_in),
    .rst_in(rst_in), .chip_en_n_in(ce_n), .read_nwrite_in(rnw),
    .ctrl_select_1_in(s1), .ctrl_select_0_in(s0), .data_in(data),
    .pal_rd_addr_in(rd_adr), .mode_reg_out(mode), .cfg_out(cfg),
    .addr_out(adr_seen), .pal_phase_out(ph), .pipe_reset_out(pipe_rst),
    .bus_10bit_out(b10), .dac_10bit_out(d10), .mux_2to1_out(mux),
    .synth_clk_sel_out(syn), .pal_init_done_out(done),
    .pal_rd_data_out(rd));
  task automatic check(input string n, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : check
  task automatic w(input logic a, b, input logic [9:0] d);
    u_rhsp_host_model.wr(1'h0, a, b, d);
  endtask : w
  task automatic put(input logic [10:0] a, input logic [7:0] d);
    u_rhsp_host_model.adr(a);
    w(1'h1, 1'h0, {2'h0, d});
  endtask : put
  task automatic mode_scn;
    w(1'h1, 1'h1, 10'h007);
    w(1'h1, 1'h1, 10'h006);
    w(1'h1, 1'h1, 10'h007);
    repeat (2) @(posedge core_clk_in);
    check("mode", 32'h07, mode);
    check("pipe_reset", 32'h1, seen);
    check("bus_10bit", 32'h1, b10);
    check("dac_10bit", 32'h1, d10);
  endtask : mode_scn
  task automatic cfg_scn;
    w(1'h0, 1'h0, 10'h005);
    w(1'h0, 1'h0, 10'h009);
    put(11'h006, 8'hE4);
    put(11'h007, 8'h40);
    put(11'h008, 8'h00);
    put(11'h00D, 8'h40);
    put(11'h004, 8'hFF);
    put(11'h00F, 8'h09);
    put(11'h00C, 8'h01);
    put(11'h009, 8'h06);
    u_rhsp_host_model.adr(11'h008);
    u_rhsp_host_model.wr(1'h1, 1'h1, 1'h0, 10'h055);
    @(posedge core_clk_in);
    check("cmd1", 32'h09, cfg.command_one);
    check("cmd2", 32'hE4, cfg.command_two);
    check("cmd3", 32'h40, cfg.command_three);
    check("cmd4", 32'h00, cfg.command_four);
    check("cmd5", 32'h40, cfg.command_five);
    check("mask", 32'hFF, cfg.pixel_mask);
    check("fb_div", 32'h09, cfg.synth_fb_divider);
    check("ref_div", 32'h01, cfg.synth_ref_divider);
    check("synth_cmd", 32'h06, cfg.synth_command);
    check("mux_2to1", 32'h1, mux);
    check("synth_sel", 32'h1, syn);
    check("addr", 32'h008, adr_seen);
  endtask : cfg_scn
  task automatic pal_scn;
    logic [7:0] pts [3] = '{8'h00, 8'h01, 8'hFF};
    u_rhsp_host_model.adr(11'h000);
    for (int i = 0; i < 256; i++) begin
      w(1'h0, 1'h1, 10'(i));
      w(1'h0, 1'h1, 10'(i) + 10'h100);
      w(1'h0, 1'h1, 10'(i) + 10'h200);
    end
    @(posedge core_clk_in);
    check("init_done", 32'h1, done);
    check("addr", 32'h000, adr_seen);
    check("phase", 32'h0, ph);
    foreach (pts[k]) begin
      rd_adr <= pts[k];
      repeat (2) @(posedge core_clk_in);
      check("palette", {2'h0, 10'(pts[k]), 10'(pts[k]) + 10'h100,
        10'(pts[k]) + 10'h200}, rd);
    end
  endtask : pal_scn
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (2) @(posedge core_clk_in);
    rst_in <= 1'h0;
    mode_scn();
    cfg_scn();
    pal_scn();
    report_and_stop();
  end
  // About 1600 cycles of traffic; the limit leaves ample margin
  initial begin
    #200000;
    bad_count++;
    report_and_stop();
  end
endmodule : test_rhsp_host_port
